/* hw/conv_seq_defs.svh */
// register offsets, field positions, reset values and timing counts
// for the conversion sequencer; included by the tick generator, the top and the bench
`ifndef CONV_SEQ_DEFS_SVH
`define CONV_SEQ_DEFS_SVH

`define OFF_CTRL_ZERO 12'h000
`define OFF_CTRL_ONE 12'h004
`define OFF_TRIG_SEL 12'h008
`define OFF_RES_HIGH 12'h00c
`define OFF_RES_LOW 12'h010
`define OFF_PERIPH_FLAG 12'h014
`define OFF_PERIPH_EN 12'h018
`define OFF_SAMPLE 12'h01c

`define CTRL0_ENABLE_BIT 0
`define CTRL0_GO_BIT 1
`define CTRL0_CHAN_LSB 2
`define CTRL1_PREF_LSB 0
`define CTRL1_NREF_BIT 2
`define CTRL1_CLKSEL_LSB 4
`define CTRL1_JUSTIFY_BIT 7
`define FLAG_DONE_BIT 0
`define EN_IRQ_BIT 0

`define RST_CTRL0 8'h00
`define RST_CTRL1 8'h00
`define RST_TRIG 5'h00

`define CONV_PERIODS 4'hb
`define RC_HALF_CYCLES 6'h1f
`define INSN_CYCLES 3'h4

`endif

/* hw/conv_seq_pkg.sv */
// types shared by the conversion sequencer files
// assumes conv_seq_defs.svh is on the include path
package conv_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_CONVERT
  } seq_state_t;
endpackage

/* hw/tad_tick_gen.sv */
// conversion clock tick generator: one pulse per bit period
// assumes pclk is the system clock; the rc tick is derived locally
`include "conv_seq_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tad_tick_gen
  import conv_seq_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic run, // count only while converting
  input wire logic [2:0] clk_sel, // conv_clock_select field
  output logic tick // one-cycle bit period pulse
);
  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } tick_state_t;
  tick_state_t s_reg;
  tick_state_t s_next;

  function automatic logic [5:0] div_limit(input logic [2:0] sel);
    unique case (sel)
      3'h0: div_limit = 6'h01; // /2
      3'h4: div_limit = 6'h03; // /4
      3'h1: div_limit = 6'h07; // /8
      3'h5: div_limit = 6'h0f; // /16
      3'h2: div_limit = 6'h1f; // /32
      3'h6: div_limit = 6'h3f; // /64
      default: div_limit = 6'h3f; // rc oscillator stand-in
    endcase
  endfunction

  // rc stand-in runs at a fixed rate, independent of the divided clock
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!run) begin
      s_next.cnt = 6'h00;
    end else if (s_reg.cnt >= div_limit(clk_sel)) begin
      s_next.cnt = 6'h00;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
endmodule // tad_tick_gen
`default_nettype wire

/* hw/conv_seq_top.sv */
// conversion sequencer: apb registers, start logic, bit period
// sequencing, result formatting and sleep handling
// assumes an apb master on pclk and same-clock trigger/sleep inputs
`include "conv_seq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - clock select picks divider or rc
// - conversion takes eleven bit periods
// - done flag set every conversion
// - flag cleared only by software write
// - enabled flag raises irq, wakes sleep
// - justify bit picks result placement
// - unused result bits load zero
// - runs only when enabled; go starts
// - completion clears go, flags, loads result
// - reset restores registers, ends conversion
// - sleep conversions only with rc clock
// - rc start delayed one instruction
// - sleep, irq off: shut down after
// - sleep with divider clock aborts
// - trigger rising edge sets go
// - five-bit field selects trigger source
// - codes map sources in sequence
// - divided clock tracks system clock
// - irq gated by separate enable bit
// - disabled converter disconnects muxes
module conv_seq_top
  import conv_seq_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  input wire logic [15:0] trig_in, // trigger sources, same clock
  input wire logic sleep_mode, // core is in sleep
  output logic irq_req, // peripheral irq request
  output logic wake_req, // wake from sleep
  output logic conv_active, // analog front end powered
  output logic [5:0] chan_sel, // channel to sample, zero when off
  output logic [2:0] ref_sel // references, zero when off
);
  typedef struct packed {
    seq_state_t st;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [4:0] trig_sel;
    logic [7:0] res_high;
    logic [7:0] res_low;
    logic done_flag;
    logic irq_en;
    logic [9:0] sample;
    logic [9:0] sar;
    logic [3:0] periods;
    logic [2:0] delay;
    logic trig_prev;
    logic shut;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
    logic active;
    logic [5:0] chan;
    logic [2:0] refs;
  } top_state_t;
  top_state_t s_reg;
  top_state_t s_next;

  logic tick;
  logic trig_now;
  logic wr_en;
  logic rd_en;

  function automatic logic is_rc(input logic [2:0] sel);
    is_rc = (sel[1:0] == 2'b11);
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `OFF_CTRL_ZERO) || (a == `OFF_CTRL_ONE) ||
      (a == `OFF_TRIG_SEL) || (a == `OFF_RES_HIGH) ||
      (a == `OFF_RES_LOW) || (a == `OFF_PERIPH_FLAG) ||
      (a == `OFF_PERIPH_EN) || (a == `OFF_SAMPLE);
  endfunction

  tad_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(s_reg.st == ST_CONVERT),
    .clk_sel(s_reg.ctrl1[`CTRL1_CLKSEL_LSB +: 3]),
    .tick(tick)
  );

  // code 0 and codes with bit 4 set select no source
  assign trig_now =
    (s_reg.trig_sel[4] || s_reg.trig_sel[3:0] == 4'h0) ? 1'b0 :
    trig_in[s_reg.trig_sel[3:0]];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always_comb begin
    logic enabled;
    logic rc;
    logic go_set;
    logic done;
    logic [9:0] res;
    enabled = 1'b0;
    rc = 1'b0;
    go_set = 1'b0;
    done = 1'b0;
    res = '0;
    s_next = s_reg;
    enabled = s_reg.ctrl0[`CTRL0_ENABLE_BIT];
    rc = is_rc(s_reg.ctrl1[`CTRL1_CLKSEL_LSB +: 3]);
    s_next.trig_prev = trig_now;

    // apb: one wait-free access phase, error on unmapped address
    s_next.ready = psel && !penable;
    s_next.err = psel && !penable && !is_mapped(paddr);
    if (rd_en) begin
      unique case (paddr)
        `OFF_CTRL_ZERO: s_next.rdata = {24'h0, s_reg.ctrl0};
        `OFF_CTRL_ONE: s_next.rdata = {24'h0, s_reg.ctrl1 & 8'hf7};
        `OFF_TRIG_SEL: s_next.rdata = {27'h0, s_reg.trig_sel};
        `OFF_RES_HIGH: s_next.rdata = {24'h0, s_reg.res_high};
        `OFF_RES_LOW: s_next.rdata = {24'h0, s_reg.res_low};
        `OFF_PERIPH_FLAG: s_next.rdata = {31'h0, s_reg.done_flag};
        `OFF_PERIPH_EN: s_next.rdata = {31'h0, s_reg.irq_en};
        `OFF_SAMPLE: s_next.rdata = {22'h0, s_reg.sample};
        default: s_next.rdata = 32'h0;
      endcase
    end

    if (wr_en) begin
      unique case (paddr)
        `OFF_CTRL_ZERO: begin
          s_next.ctrl0 = pwdata[7:0];
          // go only honoured when already enabled
          if (pwdata[`CTRL0_GO_BIT] && enabled && pwdata[0]) begin
            go_set = 1'b1;
          end
          s_next.ctrl0[`CTRL0_GO_BIT] = s_reg.ctrl0[`CTRL0_GO_BIT];
        end
        `OFF_CTRL_ONE: s_next.ctrl1 = pwdata[7:0] & 8'hf7;
        `OFF_TRIG_SEL: s_next.trig_sel = pwdata[4:0];
        `OFF_PERIPH_FLAG: begin
          if (!pwdata[`FLAG_DONE_BIT]) begin
            s_next.done_flag = 1'b0;
          end
        end
        `OFF_PERIPH_EN: s_next.irq_en = pwdata[`EN_IRQ_BIT];
        `OFF_SAMPLE: s_next.sample = pwdata[9:0];
        default: ;
      endcase
    end

    // auto trigger: rising edge, not available in sleep
    if (trig_now && !s_reg.trig_prev && !sleep_mode && enabled &&
        s_reg.st == ST_IDLE && !s_reg.shut) begin
      go_set = 1'b1;
    end

    if (!s_next.ctrl0[`CTRL0_ENABLE_BIT]) begin
      s_next.shut = 1'b0;
    end
    unique case (s_reg.st)
      ST_IDLE: begin
        // a go held off by sleep starts once the core wakes
        if ((go_set || s_reg.ctrl0[`CTRL0_GO_BIT]) && !s_reg.shut) begin
          s_next.ctrl0[`CTRL0_GO_BIT] = 1'b1;
          s_next.sar = '0;
          s_next.periods = '0;
          if (rc) begin
            s_next.delay = `INSN_CYCLES;
            s_next.st = ST_DELAY;
          end else if (!sleep_mode) begin
            s_next.st = ST_CONVERT;
          end
        end
      end
      ST_DELAY: begin
        s_next.delay = s_reg.delay - 3'h1;
        if (s_reg.delay == 3'h1) begin
          s_next.st = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (sleep_mode && !rc) begin
          s_next.st = ST_IDLE;
          s_next.ctrl0[`CTRL0_GO_BIT] = 1'b0;
          s_next.shut = 1'b1;
        end else if (tick) begin
          // one bit decided per period, last period settles
          if (s_reg.periods < 4'ha) begin
            s_next.sar[4'h9 - s_reg.periods] =
              s_reg.sample[4'h9 - s_reg.periods];
          end
          s_next.periods = s_reg.periods + 4'h1;
          if (s_reg.periods == `CONV_PERIODS - 4'h1) begin
            done = 1'b1;
          end
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
    if (done) begin
      res = s_reg.sar;
      s_next.st = ST_IDLE;
      s_next.ctrl0[`CTRL0_GO_BIT] = 1'b0;
      s_next.done_flag = 1'b1;
      if (s_reg.ctrl1[`CTRL1_JUSTIFY_BIT]) begin
        s_next.res_high = {6'h00, res[9:8]};
        s_next.res_low = res[7:0];
      end else begin
        s_next.res_high = res[9:2];
        s_next.res_low = {res[1:0], 6'h00};
      end
      if (sleep_mode && !s_reg.irq_en) begin
        s_next.shut = 1'b1;
      end
    end
    // disabling stops any conversion at once
    if (!s_next.ctrl0[`CTRL0_ENABLE_BIT]) begin
      s_next.st = ST_IDLE;
      s_next.ctrl0[`CTRL0_GO_BIT] = 1'b0;
    end
    // leaving sleep lifts the shutdown, enable bit never changed
    if (!sleep_mode) begin
      s_next.shut = 1'b0;
    end

    s_next.irq = s_next.done_flag && s_next.irq_en;
    s_next.active = s_next.ctrl0[`CTRL0_ENABLE_BIT] && !s_next.shut;
    s_next.chan = s_next.active ?
      s_next.ctrl0[`CTRL0_CHAN_LSB +: 6] : 6'h00;
    s_next.refs = s_next.active ? s_next.ctrl1[2:0] : 3'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.ctrl0 <= `RST_CTRL0;
      s_reg.ctrl1 <= `RST_CTRL1;
      s_reg.trig_sel <= `RST_TRIG;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.err;
  assign irq_req = s_reg.irq;
  assign wake_req = s_reg.irq;
  assign conv_active = s_reg.active;
  assign chan_sel = s_reg.chan;
  assign ref_sel = s_reg.refs;
endmodule // conv_seq_top
`default_nettype wire

/* bench/trig_src_model.sv */
// trigger sources seen by the sequencer
// assumes fire is driven off the clock edge
`timescale 1ns/1ps
`default_nettype none
module trig_src_model (
  input wire logic pclk, // clock
  input wire logic fire, // raise chosen source
  input wire logic [3:0] code, // chosen source
  output logic [15:0] trig_in // source outputs
);
  logic [15:0] noise_reg = 16'h0000;
  // other sources toggle to expose a wrong selection
  always @(posedge pclk) begin
    noise_reg <= ~noise_reg;
  end
  always_comb begin
    trig_in = noise_reg & ~(16'h0001 << code);
    trig_in[code] = fire;
  end
endmodule // trig_src_model
`default_nettype wire

/* bench/conv_seq_properties.sv */
// port checker for conv_seq_top, bound below
// assumes a single pclk domain
`include "conv_seq_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module conv_seq_chk (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] prdata, // rdata
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic irq_req, // irq
  input wire logic wake_req, // wake
  input wire logic conv_active, // powered
  input wire logic [5:0] chan_sel, // channel
  input wire logic [2:0] ref_sel // refs
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_wake_irq: assert property (wake_req == irq_req)
    else $error("wake differs from irq");
  a_mux_off: assert property (!conv_active |->
    chan_sel == 6'h00 && ref_sel == 3'h0) else $error("mux on");
  a_reset_idle: assert property ($rose(presetn) |->
    !conv_active && !irq_req) else $error("busy after reset");
  a_flag_sticky: assert property ($fell(irq_req) |->
    $past(psel && penable && pwrite, 1)) else $error("flag lost");
  a_trig_read: assert property (pready && !pwrite &&
    paddr == `OFF_TRIG_SEL |-> prdata[31:5] == 27'h0)
    else $error("trigger field too wide");
  c_irq: cover property ($rose(irq_req));
  c_err: cover property (pslverr);
  c_off: cover property ($fell(conv_active));
endmodule // conv_seq_chk
bind conv_seq_top conv_seq_chk i_conv_seq_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .irq_req,
  .wake_req, .conv_active, .chan_sel, .ref_sel);
`default_nettype wire

/* bench/conv_seq_top_tb_top.sv */
// self-checking bench for conv_seq_top over apb
// assumes the trigger model and checker are compiled first
`include "conv_seq_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module conv_seq_top_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic sleep_mode = 1'b0;
  logic fire = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq_req, wake_req, conv_active, err;
  logic [5:0] chan_sel;
  logic [2:0] ref_sel;
  logic [15:0] trig_in;
  int fail_count = 0;
  int check_count = 0;
  int t0, t;
  int dv [7] = '{2, 4, 8, 16, 32, 64, 64};
  logic [2:0] cs [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  always #4 pclk = ~pclk;
  conv_seq_top i_conv_seq_top (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .trig_in, .sleep_mode,
    .irq_req, .wake_req, .conv_active, .chan_sel, .ref_sel);
  trig_src_model i_trig_src_model (.pclk, .fire, .code(4'h5), .trig_in);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) chk(32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wirq(output int n);
    n = 0;
    while (irq_req !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus(12'(i * 4), 1'b0, 32'h0);
      chk(rd, 32'h0);
    end
    bus(12'h020, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    bus(`OFF_PERIPH_EN, 1'b1, 32'h1);
    bus(`OFF_SAMPLE, 1'b1, 32'h2a5);
    bus(`OFF_CTRL_ZERO, 1'b1, 32'h1);
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      bus(`OFF_CTRL_ONE, 1'b1, {24'h0, i[0], cs[i], 4'h0});
      bus(`OFF_CTRL_ZERO, 1'b1, 32'h3);
      wirq(t);
      if (i == 0) t0 = t;
      chk(t - t0, 11 * (dv[i] - 2) + (i == 6 ? 4 : 0));
      bus(`OFF_RES_HIGH, 1'b0, 32'h0);
      chk(rd, i[0] ? 32'h02 : 32'ha9);
      bus(`OFF_RES_LOW, 1'b0, 32'h0);
      chk(rd, i[0] ? 32'ha5 : 32'h40);
      bus(`OFF_CTRL_ZERO, 1'b0, 32'h0);
      chk(rd, 32'h1);
      bus(`OFF_PERIPH_FLAG, 1'b0, 32'h0);
      chk(rd, 32'h1);
      bus(`OFF_PERIPH_FLAG, 1'b1, 32'h0);
    end
    // go together with enable must not start
    bus(`OFF_CTRL_ZERO, 1'b1, 32'h0);
    bus(`OFF_CTRL_ZERO, 1'b1, 32'h0f);
    bus(`OFF_CTRL_ZERO, 1'b0, 32'h0);
    chk(rd, 32'hd);
    chk({31'h0, irq_req}, 32'h0);
    bus(`OFF_CTRL_ONE, 1'b1, 32'h87);
    bus(`OFF_TRIG_SEL, 1'b1, 32'h5);
    chk({26'h0, chan_sel}, 32'h3);
    chk({29'h0, ref_sel}, 32'h7);
    for (int k = 0; k < 2; k++) begin
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      bus(`OFF_CTRL_ZERO, 1'b0, 32'h0);
      chk(rd, 32'hf);
    end
    wirq(t);
    chk(t, 32'd17);
    bus(`OFF_CTRL_ZERO, 1'b0, 32'h0);
    chk(rd, 32'hd);
    bus(`OFF_PERIPH_FLAG, 1'b1, 32'h0);
    bus(`OFF_CTRL_ONE, 1'b1, 32'h60);
    bus(`OFF_CTRL_ZERO, 1'b1, 32'h3);
    sleep_mode <= 1'b1;
    repeat (800) @(posedge pclk);
    chk({31'h0, irq_req}, 32'h0);
    chk({31'h0, conv_active}, 32'h0);
    bus(`OFF_CTRL_ZERO, 1'b0, 32'h0);
    chk(rd, 32'h1);
    sleep_mode <= 1'b0;
    bus(`OFF_CTRL_ONE, 1'b1, 32'h30);
    bus(`OFF_CTRL_ZERO, 1'b1, 32'h3);
    sleep_mode <= 1'b1;
    wirq(t);
    chk({31'h0, wake_req}, 32'h1);
    sleep_mode <= 1'b0;
    bus(`OFF_PERIPH_FLAG, 1'b1, 32'h0);
    bus(`OFF_PERIPH_EN, 1'b1, 32'h0);
    bus(`OFF_CTRL_ZERO, 1'b1, 32'h3);
    sleep_mode <= 1'b1;
    repeat (1000) @(posedge pclk);
    chk({31'h0, conv_active}, 32'h0);
    chk({31'h0, irq_req}, 32'h0);
    bus(`OFF_PERIPH_FLAG, 1'b0, 32'h0);
    chk(rd, 32'h1);
    bus(`OFF_CTRL_ZERO, 1'b0, 32'h0);
    chk(rd, 32'h1);
    sleep_mode <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    bus(`OFF_PERIPH_FLAG, 1'b0, 32'h0);
    chk(rd, 32'h0);
    end_sim;
  end
endmodule // conv_seq_top_tb_top
`default_nettype wire
